// [core/timer_pwm_mode.sv]
`timescale 1ns/1ps
module timer_pwm_mode
  import pwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire pwm_pkg::op_mode_t op_mode,
  input wire logic [1:0] count_src_sel,
  input wire logic [1:0] trig_sel,
  input wire logic width_8bit,
  input wire logic count_start,
  input wire logic timer_wr,
  input wire logic [15:0] timer_wr_data,
  output logic [15:0] timer_rd_data,
  input wire logic irq_clear,
  output logic irq_flag,
  input wire logic timer_trigger_input_pin,
  output logic timer_pulse_output_pin
);

  import pwm_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_LEAD,
    ST_RUN
  } run_state_t;

  count_src_if cs ();

  run_state_t state_r;
  op_mode_t mode_prev_r;
  logic [15:0] reload_r;
  logic [15:0] cnt_val_r;
  logic [15:0] step_r;
  logic [7:0] pre_r;
  logic start_prev_r;
  logic pulse_out_r;
  logic irq_r;
  logic ext_edge;
  logic pwm_mode;
  logic counting;
  logic start_rise;
  logic trig;
  logic tick;
  logic pre_wrap;
  logic high_cond;
  logic out_nxt;
  logic reload_evt;
  logic irq_set;

  ////////////////////////////////////////////////////////////////////////
  // count source and trigger

  assign cs.sel = count_src_sel;
  assign tick = cs.tick;

  count_source_div count_source_div_i
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cs(cs)
  );

  trigger_edge_det trigger_edge_det_i
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(timer_trigger_input_pin),
    .rise_sel(trig_sel[TRIG_RISE_BIT]),
    .cs(cs),
    .edge_r(ext_edge)
  );

  assign pwm_mode = op_mode == MODE_PWM;
  assign counting = state_r != ST_IDLE;
  assign start_rise = count_start && !start_prev_r;

  always_comb
  begin
    if (!trig_sel[TRIG_EXT_BIT])
      trig = start_rise;
    else
      trig = ext_edge && count_start;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      start_prev_r <= 1'b0;
    else
      start_prev_r <= count_start;
  end

  ////////////////////////////////////////////////////////////////////////
  // modulator sequencing

  // prescaler only divides in 8-bit operation
  assign pre_wrap = !width_8bit || pre_r == cnt_val_r[7:0];
  assign reload_evt = state_r == ST_RUN && count_start && tick && pre_wrap &&
                      (width_8bit ? step_r[7:0] == LAST_STEP_8
                                  : step_r == LAST_STEP_16);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      step_r <= RESET_WORD;
      pre_r <= 8'h00;
    end
    else if (!pwm_mode || (counting && !count_start))
    begin
      state_r <= ST_IDLE;
      step_r <= RESET_WORD;
      pre_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          if (trig)
          begin
            step_r <= RESET_WORD;
            pre_r <= 8'h00;
            state_r <= ST_ARM;
          end
        end
        // a trigger lands between ticks: wait for one so the first step
        // lasts a whole count period and the widths come out exact
        ST_ARM:
        begin
          if (tick)
          begin
            if (width_8bit && cnt_val_r[15:8] != 8'h00)
              state_r <= ST_LEAD;
            else
              state_r <= ST_RUN;
          end
        end
        // low lead lasts n prescaled steps before the first period
        ST_LEAD:
        begin
          if (tick)
          begin
            if (pre_wrap)
            begin
              pre_r <= 8'h00;
              if (step_r[7:0] == cnt_val_r[15:8] - 8'h01)
              begin
                state_r <= ST_RUN;
                step_r <= RESET_WORD;
              end
              else
                step_r <= step_r + 16'h0001;
            end
            else
              pre_r <= pre_r + 8'h01;
          end
        end
        // triggers are simply not looked at here
        ST_RUN:
        begin
          if (tick)
          begin
            if (!pre_wrap)
              pre_r <= pre_r + 8'h01;
            else
            begin
              pre_r <= 8'h00;
              if (reload_evt)
                step_r <= RESET_WORD;
              else
                step_r <= step_r + 16'h0001;
            end
          end
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reload register and counter value

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      reload_r <= RESET_WORD;
      cnt_val_r <= RESET_WORD;
    end
    else
    begin
      if (timer_wr)
        reload_r <= timer_wr_data;
      if (timer_wr && !counting)
        cnt_val_r <= timer_wr_data;
      else if (reload_evt || (state_r == ST_IDLE && trig && pwm_mode))
        cnt_val_r <= reload_r;
    end
  end

  // counter contents are not visible in this mode
  assign timer_rd_data = READ_FILL;

  ////////////////////////////////////////////////////////////////////////
  // pulse output and interrupt request

  always_comb
  begin
    if (width_8bit)
      high_cond = step_r[7:0] < cnt_val_r[15:8];
    else
      high_cond = step_r < cnt_val_r;
  end

  assign out_nxt = pwm_mode && count_start && state_r == ST_RUN &&
                   high_cond;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      pulse_out_r <= 1'b0;
    else
      pulse_out_r <= out_nxt;
  end

  assign timer_pulse_output_pin = pulse_out_r;

  // a fall caused by leaving the mode is not a pulse edge
  assign irq_set = (pulse_out_r && !out_nxt && pwm_mode) ||
                   (pwm_mode && mode_prev_r != MODE_PWM);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      irq_r <= 1'b0;
      mode_prev_r <= MODE_TIMER;
    end
    else
    begin
      irq_r <= irq_set || (irq_r && !irq_clear);
      mode_prev_r <= op_mode;
    end
  end

  assign irq_flag = irq_r;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  irq_on_fall_a: assert property (
    $fell(pulse_out_r) && $past(pwm_mode) |-> irq_r)
    else $error("falling pulse did not raise request");

  stop_write_a: assert property (timer_wr && !counting |=>
    cnt_val_r == $past(timer_wr_data) && reload_r == $past(timer_wr_data))
    else $error("stopped write did not load both");

  run_write_a: assert property (timer_wr && counting && !reload_evt |=>
    cnt_val_r == $past(cnt_val_r) && reload_r == $past(timer_wr_data))
    else $error("running write touched the counter");

  trig_ignored_a: assert property (
    state_r == ST_RUN && trig && count_start && pwm_mode && !tick |=>
    state_r == ST_RUN && step_r == $past(step_r))
    else $error("trigger disturbed running output");

  start_needed_a: assert property (state_r == ST_IDLE && !count_start |=>
    state_r == ST_IDLE)
    else $error("started without count start bit");

  entry_low_a: assert property ($rose(pwm_mode) |->
    !pulse_out_r ##1 !pulse_out_r)
    else $error("output not low on mode entry");

  zero_width_a: assert property (state_r == ST_RUN && !width_8bit &&
    cnt_val_r == RESET_WORD |=> !pulse_out_r)
    else $error("zero width produced a pulse");

  lead_low_a: assert property (state_r == ST_LEAD |=> !pulse_out_r)
    else $error("output high during lead");

  stop_high_a: assert property (state_r == ST_RUN && pulse_out_r &&
    !count_start && pwm_mode |=> !pulse_out_r && irq_r && state_r == ST_IDLE)
    else $error("stop while high handled wrongly");

  entry_irq_a: assert property (
    pwm_mode && mode_prev_r != MODE_PWM |=> irq_r)
    else $error("mode entry did not raise request");

  period_wrap_a: assert property (state_r == ST_RUN && !width_8bit &&
    count_start && pwm_mode && tick && step_r == LAST_STEP_16 |=>
    step_r == RESET_WORD)
    else $error("16-bit period did not wrap");

  run16_c: cover property (state_r == ST_RUN && !width_8bit ##1
    $fell(pulse_out_r));
  run8_c: cover property (state_r == ST_LEAD ##1 state_r == ST_RUN);
  stop_c: cover property (pulse_out_r && !count_start && state_r == ST_RUN);
  reload_c: cover property (reload_evt && reload_r != cnt_val_r);

endmodule

// [core/pwm_pkg.sv]
// Notes on behaviour
// - pulse falling edge sets interrupt request flag
// - timer register reads return no counter value
// - write while stopped loads reload and counter
// - write while counting updates reload only
// - bits 7:6 pick count source divider
// - bits 4:3 pick internal or external trigger
// - triggers ignored once pulse output started
// - internal trigger: writing start bit one
// - external edge polarity by bit 3, needs start
// - entering this mode drives output low
// - valid trigger starts counter and pulse output
// - reload each period and keep counting
// - width bit zero: one 16-bit modulator
// - width bit one: 8-bit modulator plus prescaler
// - zero width keeps output low, no request
// - 8-bit: low lead of high width first
// - stopping ends high pulse with request
// - mode entry sets interrupt request flag
// - 16-bit period 65535 ticks, high n ticks
// - 8-bit period (m+1) times 255 ticks
package pwm_pkg;

  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_EVENT,
    MODE_ONESHOT,
    MODE_PWM
  } op_mode_t;

  // count source select codes
  localparam logic [1:0] SRC_DIV_2 = 2'h0;
  localparam logic [1:0] SRC_DIV_16 = 2'h1;
  localparam logic [1:0] SRC_DIV_64 = 2'h2;
  localparam logic [1:0] SRC_DIV_512 = 2'h3;

  // low bits of the free divider that must all be one for a tick
  localparam logic [8:0] MASK_DIV_2 = 9'h001;
  localparam logic [8:0] MASK_DIV_16 = 9'h00f;
  localparam logic [8:0] MASK_DIV_64 = 9'h03f;
  localparam logic [8:0] MASK_DIV_512 = 9'h1ff;

  // field positions inside trig_sel
  localparam int TRIG_EXT_BIT = 1;
  localparam int TRIG_RISE_BIT = 0;

  // last step of a period: 65535 and 255 ticks/steps per period
  localparam logic [15:0] LAST_STEP_16 = 16'hfffe;
  localparam logic [7:0] LAST_STEP_8 = 8'hfe;

  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] READ_FILL = 16'h0000;

endpackage

// [core/count_src_if.sv]
`timescale 1ns/1ps
interface count_src_if;
  logic tick;
  logic [1:0] sel;

  modport source
  (
    output tick,
    input sel
  );

  modport ctrl
  (
    input tick,
    output sel
  );

  modport watch
  (
    input tick
  );
endinterface

// [core/count_source_div.sv]
`timescale 1ns/1ps
module count_source_div
  import pwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  count_src_if.source cs
);

  logic [8:0] div_r;

  function automatic logic [8:0] div_mask(input logic [1:0] s);
    case (s)
      SRC_DIV_2: div_mask = MASK_DIV_2;
      SRC_DIV_16: div_mask = MASK_DIV_16;
      SRC_DIV_64: div_mask = MASK_DIV_64;
      default: div_mask = MASK_DIV_512;
    endcase
  endfunction

  // free-running so a source change never needs a restart
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      div_r <= 9'h000;
    else
      div_r <= div_r + 9'h001;
  end

  assign cs.tick = (div_r & div_mask(cs.sel)) == div_mask(cs.sel);

  div2_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cs.tick && cs.sel == SRC_DIV_2) ##1 (cs.sel == SRC_DIV_2)
    |-> !cs.tick ##1 (cs.tick || cs.sel != SRC_DIV_2))
    else $error("divide by 2 tick spacing wrong");

endmodule

// [core/trigger_edge_det.sv]
`timescale 1ns/1ps
module trigger_edge_det
  import pwm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin_in,
  input wire logic rise_sel,
  count_src_if.watch cs,
  output logic edge_r
);

  logic sync1_r;
  logic sync2_r;
  logic smp_r;
  logic primed_r;

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end
    else
    begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // the pin is looked at only on count ticks, one event per edge
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      smp_r <= 1'b0;
      primed_r <= 1'b0;
      edge_r <= 1'b0;
    end
    else
    begin
      edge_r <= 1'b0;
      if (cs.tick)
      begin
        smp_r <= sync2_r;
        primed_r <= 1'b1;
        if (primed_r)
          edge_r <= rise_sel ? (sync2_r && !smp_r)
                             : (!sync2_r && smp_r);
      end
    end
  end

endmodule

// [tb/trig_source.sv]
`timescale 1ns/1ps
module trig_source
(
  input wire logic clk_sys,
  input wire logic pulse_in,
  output logic pin_out
);
  int falls;
  initial
  begin
    pin_out = 1'b0;
    falls = 0;
  end
  ////////////////////////////////////////////////////////////////////////
  // load side: counts pulses that reach the output pin
  always @(negedge pulse_in)
  begin
    falls++;
  end
  ////////////////////////////////////////////////////////////////////////
  // a level is held for hold clocks, 12 in the tests, enough for divide-by-2 ticks to sample it several times
  task automatic set_pin(input logic v, input int hold);
    @(posedge clk_sys);
    #1;
    pin_out = v;
    repeat (hold) @(posedge clk_sys);
    #1;
  endtask
endmodule

// [tb/test_timer_pwm_mode.sv]
`timescale 1ns/1ps
module test_timer_pwm_mode;
  import pwm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  op_mode_t op_mode = MODE_PWM;
  logic [1:0] count_src_sel = 2'h0;
  logic [1:0] trig_sel = 2'h0;
  logic width_8bit = 1'b0;
  logic count_start = 1'b0;
  logic timer_wr = 1'b0;
  logic [15:0] timer_wr_data = 16'h0000;
  logic irq_clear = 1'b0;
  logic [15:0] timer_rd_data;
  logic irq_flag, pin, trig_pin;
  logic prev = 1'b0;
  logic mon = 1'b0;
  int num_errors = 0, compares = 0, cyc = 0, rises = 0;
  int last_rise = 0, per = 0, t0, n, m, dv, r0;
  int wq[$];
  logic [31:0] seed = 32'h6e5ad318;

  timer_pwm_mode timer_pwm_mode_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .op_mode(op_mode), .count_src_sel(count_src_sel), .trig_sel(trig_sel),
    .width_8bit(width_8bit), .count_start(count_start),
    .timer_wr(timer_wr), .timer_wr_data(timer_wr_data),
    .timer_rd_data(timer_rd_data), .irq_clear(irq_clear),
    .irq_flag(irq_flag), .timer_trigger_input_pin(trig_pin),
    .timer_pulse_output_pin(pin));
  trig_source trig_source_i (.clk_sys(clk_sys), .pulse_in(pin),
    .pin_out(trig_pin));

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic close_out();
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [15:0] d);
    timer_wr = 1'b1;
    timer_wr_data = d;
    step(1);
    timer_wr = 1'b0;
  endtask

  task automatic clr();
    irq_clear = 1'b1;
    step(1);
    irq_clear = 1'b0;
    step(1);
  endtask

  task automatic stop();
    count_start = 1'b0;
    step(3);
  endtask

  task automatic arm(input int p);
    last_rise = 0;
    per = p;
    mon = 1'b1;
  endtask

  // waits are bounded; the cycle ceiling below catches a real hang
  task automatic wait_q();
    int k;
    k = 0;
    while (wq.size() > 0 && k < 40000)
    begin
      step(1);
      k++;
    end
    if (k >= 40000)
    begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic wait_hi();
    int k;
    k = 0;
    while (pin !== 1'b1 && k < 40000)
    begin
      step(1);
      k++;
    end
    if (k >= 40000)
    begin
      num_errors++;
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watcher: high widths come off the queue, periods match per
  always @(posedge clk_sys)
  begin
    cyc++;
    if (pin === 1'b1 && prev === 1'b0)
    begin
      rises++;
      if (mon && last_rise != 0 && per != 0)
        check(cyc - last_rise, per);
      last_rise = cyc;
    end
    if (pin === 1'b0 && prev === 1'b1 && mon)
    begin
      check(cyc - last_rise, wq.size() ? wq.pop_front() : -1);
      check(irq_flag, 1'b1);
    end
    prev = pin;
    if (cyc >= 60000)
    begin
      num_errors++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    step(2);
    rst_n = 1'b1;
    step(3);
    check(irq_flag, 1'b1);
    check(pin, 1'b0);
    check(timer_rd_data, READ_FILL);
    clr();
    op_mode = MODE_TIMER;
    step(2);
    op_mode = MODE_PWM;
    step(3);
    check(irq_flag, 1'b1);
    clr();
    // 16-bit, div 2: five ticks high
    wr(16'h0005);
    arm(0);
    wq.push_back(10);
    count_start = 1'b1;
    wait_q();
    clr();
    stop();
    check(irq_flag, 1'b0);
    // zero width never pulses
    wr(16'h0000);
    r0 = rises;
    count_start = 1'b1;
    step(300);
    check(rises - r0, 0);
    check(irq_flag, 1'b0);
    stop();
    // 8-bit over every count source, random width and prescale
    width_8bit = 1'b1;
    for (int s = 0; s < 4; s++)
    begin
      count_src_sel = s[1:0];
      trig_sel = {1'b0, s[0]};
      dv = (s == 0) ? 2 : (s == 1) ? 16 : (s == 2) ? 64 : 512;
      n = 1 + int'(xs() % 4);
      m = int'(xs() % 2);
      wr({n[7:0], m[7:0]});
      arm(0);
      wq.push_back(n * (m + 1) * dv);
      t0 = cyc;
      count_start = 1'b1;
      wait_hi();
      check(cyc - t0 >= n * (m + 1) * dv, 1'b1);
      wait_q();
      clr();
      stop();
      check(irq_flag, 1'b0);
    end
    // write while running lands only at the next reload
    count_src_sel = SRC_DIV_2;
    wr(16'h0300);
    arm(510);
    wq.push_back(6);
    wq.push_back(12);
    count_start = 1'b1;
    step(2);
    wr(16'h0600);
    wait_q();
    wait_hi();
    mon = 1'b0;
    stop();
    check(pin, 1'b0);
    check(irq_flag, 1'b1);
    clr();
    // external edges: polarity, gating by start bit, retrigger ignored
    for (int r = 0; r < 2; r++)
    begin
      trig_sel = {1'b1, r[0]};
      wr(16'h0200);
      arm(510);
      r0 = rises;
      t0 = trig_source_i.falls;
      trig_source_i.set_pin(!r[0], 12);
      trig_source_i.set_pin(r[0], 12);
      check(rises - r0, 0);
      count_start = 1'b1;
      trig_source_i.set_pin(!r[0], 12);
      check(rises - r0, 0);
      repeat (3) wq.push_back(4);
      trig_source_i.set_pin(r[0], 12);
      trig_source_i.set_pin(!r[0], 12);
      trig_source_i.set_pin(r[0], 12);
      wait_q();
      mon = 1'b0;
      stop();
      check(pin, 1'b0);
      check(trig_source_i.falls - t0, 3);
      clr();
    end
    close_out();
  end
endmodule
